// [core/pobk_defs.svh]
// register offsets, field positions, reset values and sizes for the output stage
`ifndef POBK_DEFS_SVH
`define POBK_DEFS_SVH
`define POBK_ADDR_W 4
`define POBK_OFS_OEN 4'h0
`define POBK_OFS_POL 4'h1
`define POBK_OFS_BLNK 4'h2
`define POBK_OFS_REBS 4'h3
`define POBK_OFS_FEBS 4'h4
`define POBK_OFS_BLTIME 4'h5
`define POBK_OFS_STAT 4'h6
`define POBK_RST_REG 8'h00
`define POBK_MASK_OUT_FULL 8'h3F
`define POBK_MASK_OUT_AB 8'h03
`define POBK_MASK_POL_IN 8'h40
`define POBK_MASK_BLNK 8'h33
`define POBK_MASK_SRC 8'h8E
`define POBK_BIT_POL_IN 6
`define POBK_FEBM_LSB 4
`define POBK_REBM_LSB 0
`define POBK_N_OUT 6
`define POBK_N_SRC 4
`endif

// [core/pobk_pin_stage.sv]
`timescale 1ns/1ps
// one output lane: polarity and pin gating
module pobk_pin_stage (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic pwm_i,
    input wire logic enable_i,
    input wire logic invert_i,
    output logic pin_o,
    output logic pin_oe_o
);
    typedef struct packed {
        logic pin;
        logic oe;
    } pobk_lane_t;
    pobk_lane_t q;
    pobk_lane_t next_q;
    always_comb begin
        next_q.pin = pwm_i ^ invert_i;
        next_q.oe = enable_i;
    end
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign pin_o = q.pin;
    assign pin_oe_o = q.oe;
endmodule : pobk_pin_stage

// [core/pobk_pkg.sv]
// types for the output gating, polarity and blanking block
package pobk_pkg;
    typedef enum logic [1:0] {
        POBK_BM_NONE = 2'h0,
        POBK_BM_IMMEDIATE = 2'h1,
        POBK_BM_RSVD2 = 2'h2,
        POBK_BM_RSVD3 = 2'h3
    } pobk_blank_mode_t;
    typedef enum logic [1:0] {
        POBK_ST_IDLE = 2'b00,
        POBK_ST_RISE = 2'b01,
        POBK_ST_FALL = 2'b11
    } pobk_blank_state_t;
endpackage : pobk_pkg

// [core/pobk_top.sv]
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// register file, pin gating and edge blanking of the pwm output stage
`include "pobk_defs.svh"
//Function
// - enable bit gives pin to pwm
// - second instance keeps outputs A, B only
// - unimplemented bits read zero, ignore writes
// - polarity bits invert outputs and event input
// - falling blank mode 00 none, 01 immediate
// - rising blank mode 00 none, 01 immediate
// - implemented bits read/write, clear on reset
// - blanked sources cannot cause events
module pobk_top #(
    parameter bit FULL_OUTPUTS = 1'b1
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [`POBK_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WRITE_I,
    input wire logic READ_I,
    output logic [7:0] RDATA_O,
    input wire logic [`POBK_N_OUT-1:0] PWM_I,
    input wire logic PWM_RISE_I,
    input wire logic PWM_FALL_I,
    input wire logic EXTERNAL_EVENT_INPUT_I,
    input wire logic [`POBK_N_SRC-2:0] CMP_EVENT_I,
    output logic [`POBK_N_OUT-1:0] PIN_O,
    output logic [`POBK_N_OUT-1:0] PIN_OE_O,
    output logic EVENT_ACTIVE_O,
    output logic [`POBK_N_SRC-1:0] EVENT_QUALIFIED_O,
    output logic BLANK_ACTIVE_O
);
    import pobk_pkg::*;
    localparam logic [7:0] OUT_MASK = FULL_OUTPUTS ? `POBK_MASK_OUT_FULL : `POBK_MASK_OUT_AB;
    typedef struct packed {
        logic [7:0] output_gate_enable;
        logic [7:0] signal_polarity;
        logic [7:0] edge_blanking_mode;
        logic [7:0] rise_blank_src;
        logic [7:0] fall_blank_src;
        logic [7:0] blank_time;
        logic [7:0] blank_count;
        pobk_blank_state_t bstate;
        logic [1:0] ext_sync;
        logic [5:0] cmp_sync1;
        logic [3:0] cmp_sync2;
        logic [3:0] qualified;
        logic [7:0] rdata;
    } pobk_state_t;
    pobk_state_t q;
    pobk_state_t next_q;
    pobk_blank_mode_t falling_blank_mode;
    pobk_blank_mode_t rising_blank_mode;
    logic event_input_invert;
    logic [3:0] raw_src;
    logic [3:0] blank_sel;
    logic [`POBK_N_OUT-1:0] output_drive_enable;
    logic [`POBK_N_OUT-1:0] output_invert;
    assign falling_blank_mode = pobk_blank_mode_t'(q.edge_blanking_mode[`POBK_FEBM_LSB +: 2]);
    assign rising_blank_mode = pobk_blank_mode_t'(q.edge_blanking_mode[`POBK_REBM_LSB +: 2]);
    assign event_input_invert = q.signal_polarity[`POBK_BIT_POL_IN];
    assign output_drive_enable = q.output_gate_enable[`POBK_N_OUT-1:0];
    assign output_invert = q.signal_polarity[`POBK_N_OUT-1:0];
    // source 0 is the event pin after polarity, 1..3 the comparators
    assign raw_src = {q.cmp_sync2[3:1], q.ext_sync[1] ^ event_input_invert};
    always_comb begin
        next_q = q;
        // two-flop synchroniser for the event pin, three flops for the comparator inputs
        next_q.ext_sync = {q.ext_sync[0], EXTERNAL_EVENT_INPUT_I};
        next_q.cmp_sync1 = {q.cmp_sync1[2:0], CMP_EVENT_I};
        next_q.cmp_sync2 = {q.cmp_sync1[5:3], 1'b0};
        // register writes keep only implemented bits
        if (WRITE_I) begin
            if (ADDR_I == `POBK_OFS_OEN) begin
                next_q.output_gate_enable = WDATA_I & OUT_MASK;
            end else if (ADDR_I == `POBK_OFS_POL) begin
                next_q.signal_polarity = WDATA_I & (OUT_MASK | `POBK_MASK_POL_IN);
            end else if (ADDR_I == `POBK_OFS_BLNK) begin
                next_q.edge_blanking_mode = WDATA_I & `POBK_MASK_BLNK;
            end else if (ADDR_I == `POBK_OFS_REBS) begin
                next_q.rise_blank_src = WDATA_I & `POBK_MASK_SRC;
            end else if (ADDR_I == `POBK_OFS_FEBS) begin
                next_q.fall_blank_src = WDATA_I & `POBK_MASK_SRC;
            end else if (ADDR_I == `POBK_OFS_BLTIME) begin
                next_q.blank_time = WDATA_I;
            end
        end
        // blanking window; reserved codes behave as no blanking
        // the window opens on the edge cycle itself, so that edge is already masked
        blank_sel = 4'h0;
        case (q.bstate)
            POBK_ST_RISE: blank_sel = {q.rise_blank_src[3:1], q.rise_blank_src[7]};
            POBK_ST_FALL: blank_sel = {q.fall_blank_src[3:1], q.fall_blank_src[7]};
            default: blank_sel = 4'h0;
        endcase
        if (PWM_RISE_I && rising_blank_mode == POBK_BM_IMMEDIATE && q.blank_time != 8'h00) begin
            next_q.bstate = POBK_ST_RISE;
            next_q.blank_count = q.blank_time - 8'h01;
            blank_sel = {q.rise_blank_src[3:1], q.rise_blank_src[7]};
        end else if (PWM_FALL_I && falling_blank_mode == POBK_BM_IMMEDIATE && q.blank_time != 8'h00) begin
            next_q.bstate = POBK_ST_FALL;
            next_q.blank_count = q.blank_time - 8'h01;
            blank_sel = {q.fall_blank_src[3:1], q.fall_blank_src[7]};
        end else begin
            case (q.bstate)
                POBK_ST_IDLE: begin
                    next_q.blank_count = 8'h00;
                end
                default: begin
                    if (q.blank_count == 8'h00) begin
                        next_q.bstate = POBK_ST_IDLE;
                    end else begin
                        next_q.blank_count = q.blank_count - 8'h01;
                    end
                end
            endcase
        end
        next_q.qualified = raw_src & ~blank_sel;
        // read data stands one cycle after the strobe; unmapped reads zero
        next_q.rdata = 8'h00;
        if (READ_I) begin
            if (ADDR_I == `POBK_OFS_OEN) begin
                next_q.rdata = q.output_gate_enable;
            end else if (ADDR_I == `POBK_OFS_POL) begin
                next_q.rdata = q.signal_polarity;
            end else if (ADDR_I == `POBK_OFS_BLNK) begin
                next_q.rdata = q.edge_blanking_mode;
            end else if (ADDR_I == `POBK_OFS_REBS) begin
                next_q.rdata = q.rise_blank_src;
            end else if (ADDR_I == `POBK_OFS_FEBS) begin
                next_q.rdata = q.fall_blank_src;
            end else if (ADDR_I == `POBK_OFS_BLTIME) begin
                next_q.rdata = q.blank_time;
            end else if (ADDR_I == `POBK_OFS_STAT) begin
                next_q.rdata = {4'h0, raw_src};
            end
        end
    end
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    // lanes C..F never enable their pins on the reduced instance since their enable bits never set
    for (genvar i = 0; i < `POBK_N_OUT; i++) begin : g_lane
        pobk_pin_stage u_lane (
            .CLOCK_I(CLOCK_I),
            .RESET_I(RESET_I),
            .pwm_i(PWM_I[i]),
            .enable_i(output_drive_enable[i]),
            .invert_i(output_invert[i]),
            .pin_o(PIN_O[i]),
            .pin_oe_o(PIN_OE_O[i])
        );
    end
    assign RDATA_O = q.rdata;
    assign EVENT_ACTIVE_O = raw_src[0];
    assign EVENT_QUALIFIED_O = q.qualified;
    assign BLANK_ACTIVE_O = (q.bstate != POBK_ST_IDLE);
endmodule : pobk_top

// [sim/pobk_pads.sv]
// pads shared by the pwm lanes and ordinary port logic
`timescale 1ns/1ps
module pobk_pads (
    input wire logic [5:0] pin_i,
    input wire logic [5:0] pin_oe_i,
    input wire logic [5:0] port_i,
    output logic [5:0] pad_o
);
    // per lane: port logic keeps any pin the stage does not claim
    assign pad_o = (pin_oe_i & pin_i) | (~pin_oe_i & port_i);
endmodule : pobk_pads

// [sim/pobk_sva.sv]
// port-level checks of the pwm output stage
`timescale 1ns/1ps
module pobk_sva #(
    parameter bit FULL_OUTPUTS = 1'b1
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WRITE_I,
    input wire logic READ_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [5:0] PWM_I,
    input wire logic PWM_RISE_I,
    input wire logic PWM_FALL_I,
    input wire logic EVENT_ACTIVE_O,
    input wire logic [3:0] EVENT_QUALIFIED_O,
    input wire logic [5:0] PIN_O,
    input wire logic [5:0] PIN_OE_O,
    input wire logic BLANK_ACTIVE_O
);
    logic [7:0] mode;
    logic [7:0] btime;
    // lanes C..F are absent on the reduced instance
    localparam logic [5:0] LANE_MASK = FULL_OUTPUTS ? 6'h3F : 6'h03;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    // shadow copies so the rise and fall window checks only fire when blanking is armed, and the no-blank check only when the mode is zero
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode <= 8'h00;
            btime <= 8'h00;
        end else if (WRITE_I) begin
            if (ADDR_I == 4'h2) mode <= WDATA_I & 8'h33;
            if (ADDR_I == 4'h5) btime <= WDATA_I;
        end
    end
    sequence s_rd(logic [3:0] a);
        READ_I && ADDR_I == a;
    endsequence
    sequence s_wr_once(logic [3:0] a);
        WRITE_I && ADDR_I == a ##1 !WRITE_I;
    endsequence
    chk_rd_quiet: assert property (!READ_I |=> RDATA_O == 8'h00) else $error("read data not idle");
    chk_oen_unimpl: assert property (s_rd(4'h0) |=> RDATA_O[7:6] == 2'h0) else $error("enable top bits set");
    chk_pol_unimpl: assert property (s_rd(4'h1) |=> !RDATA_O[7]) else $error("polarity bit 7 set");
    chk_blnk_unimpl: assert property (s_rd(4'h2) |=> (RDATA_O & 8'hCC) == 8'h00) else $error("blank gaps set");
    chk_oe_follow: assert property (s_wr_once(4'h0) |=> PIN_OE_O == ($past(WDATA_I[5:0], 2) & LANE_MASK))
        else $error("pin enable mismatch");
    chk_pol_follow: assert property (s_wr_once(4'h1) |=>
        PIN_O == ($past(PWM_I) ^ ($past(WDATA_I[5:0], 2) & LANE_MASK)))
        else $error("pin polarity mismatch");
    chk_lane_mask: assert property ((PIN_OE_O & ~LANE_MASK) == 6'h00) else $error("absent lane enabled");
    chk_rise_window: assert property (PWM_RISE_I && mode[1:0] == 2'h1 && btime != 8'h00 |=> BLANK_ACTIVE_O)
        else $error("rise window not open");
    chk_fall_window: assert property (PWM_FALL_I && mode[5:4] == 2'h1 && btime != 8'h00 |=> BLANK_ACTIVE_O)
        else $error("fall window not open");
    chk_no_blank: assert property (!BLANK_ACTIVE_O && mode == 8'h00 |=> !BLANK_ACTIVE_O)
        else $error("window without mode");
    chk_qual_cause: assert property (EVENT_QUALIFIED_O[0] |-> $past(EVENT_ACTIVE_O))
        else $error("qualified without event");
endmodule : pobk_sva

// [sim/tb.sv]
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
    logic clk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0, rise = 1'h0, fall = 1'h0, ext = 1'h1;
    logic [3:0] addr = 4'h0;
    logic [2:0] cmp = 3'h0;
    logic [7:0] rdata_ab;
    logic [5:0] oe_ab;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [5:0] pwm = 6'h0F, pin, oe, pad;
    logic ev_act, blank;
    logic [3:0] qual;
    logic [7:0] msk [6] = '{8'h3F, 8'h7F, 8'h33, 8'h8E, 8'h8E, 8'hFF};
    logic [7:0] msk_ab [6] = '{8'h03, 8'h43, 8'h33, 8'h8E, 8'h8E, 8'hFF};
    int err_total = 0, num_checks = 0;
    pobk_top u_pobk_top (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WRITE_I(wr_s),
        .READ_I(rd_s), .RDATA_O(rdata), .PWM_I(pwm), .PWM_RISE_I(rise), .PWM_FALL_I(fall),
        .EXTERNAL_EVENT_INPUT_I(ext), .CMP_EVENT_I(cmp), .PIN_O(pin), .PIN_OE_O(oe),
        .EVENT_ACTIVE_O(ev_act), .EVENT_QUALIFIED_O(qual), .BLANK_ACTIVE_O(blank));
    // reduced instance shares the bus so both answer the same reads
    pobk_top #(.FULL_OUTPUTS(1'b0)) u_pobk_top_ab (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WRITE_I(wr_s), .READ_I(rd_s), .RDATA_O(rdata_ab), .PWM_I(pwm), .PWM_RISE_I(rise), .PWM_FALL_I(fall),
        .EXTERNAL_EVENT_INPUT_I(ext), .CMP_EVENT_I(cmp), .PIN_O(), .PIN_OE_O(oe_ab), .EVENT_ACTIVE_O(),
        .EVENT_QUALIFIED_O(), .BLANK_ACTIVE_O());
    pobk_pads u_pobk_pads (.pin_i(pin), .pin_oe_i(oe), .port_i(6'h2A), .pad_o(pad));
    initial begin forever #12.5 clk = ~clk; end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'h1;
        @(posedge clk);
        wr_s <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge clk);
        rd_s <= 1'h0;
        @(negedge clk);
        `CHK(rdata, exp)
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // one edge event, then the window must close again well after four cycles
    task automatic pulse(input logic r, input logic exp, input logic [3:0] q_exp);
        @(posedge clk);
        rise <= r;
        fall <= !r;
        @(posedge clk);
        rise <= 1'h0;
        fall <= 1'h0;
        @(negedge clk);
        `CHK(blank, exp)
        `CHK(qual, q_exp)
        settle(6);
        `CHK({blank, qual}, 5'h0B)
    endtask : pulse
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0], 8'h00);
            wr(i[3:0], 8'hFF);
            rd(i[3:0], msk[i]);
            `CHK(rdata_ab, msk_ab[i])
            wr(i[3:0], 8'h00);
            rd(i[3:0], 8'h00);
        end
        rd(4'hF, 8'h00);
        wr(4'h0, 8'h15);
        settle(2);
        `CHK(oe, 6'h15)
        `CHK(oe_ab, 6'h01)
        `CHK(pad, 6'h2F)
        wr(4'h1, 8'h3C);
        wr(4'h0, 8'h3F);
        settle(3);
        `CHK(pad, 6'h33)
        `CHK(ev_act, 1'h1)
        wr(4'h1, 8'h40);
        settle(3);
        `CHK(ev_act, 1'h0)
        wr(4'h1, 8'h00);
        wr(4'h5, 8'h04);
        wr(4'h3, 8'h8A);
        wr(4'h4, 8'h80);
        cmp <= 3'h5;
        // three sync flops plus the qualified register
        settle(4);
        `CHK(qual, 4'hB)
        rd(4'h6, 8'h0B);
        wr(4'h2, 8'h01);
        pulse(1'h1, 1'h1, 4'h0);
        wr(4'h2, 8'h10);
        pulse(1'h0, 1'h1, 4'hA);
        pulse(1'h1, 1'h0, 4'hB);
        wr(4'h2, 8'h00);
        pulse(1'h0, 1'h0, 4'hB);
        wr(4'h1, 8'h41);
        // second reset in mid-run must clear the enable and polarity fields again
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        `CHK(oe, 6'h00)
        give_verdict();
    end
    // the sequence needs well under 400 cycles
    initial begin
        #20us;
        err_total++;
        give_verdict();
    end
endmodule : tb
bind pobk_top pobk_sva #(.FULL_OUTPUTS(FULL_OUTPUTS)) u_pobk_sva (.CLOCK_I, .RESET_I, .ADDR_I, .WDATA_I,
    .WRITE_I, .READ_I, .RDATA_O,
    .PWM_I, .PWM_RISE_I, .PWM_FALL_I, .EVENT_ACTIVE_O, .EVENT_QUALIFIED_O, .PIN_O, .PIN_OE_O, .BLANK_ACTIVE_O);
